/* File: tmrc_pkg.sv */
package tmrc_pkg;
   // register byte addresses (one aligned word each)
   localparam logic [3:0] ADDR_CTRL0 = 4'h0;
   localparam logic [3:0] ADDR_CTRL1 = 4'h4;
   localparam logic [3:0] ADDR_CNTL = 4'h8;
   localparam logic [3:0] ADDR_CNTH = 4'hC;
   // irq flag and enable, stands for the interrupt request/enable pair
   localparam logic [3:0] ADDR_IRQ = 4'h0;
   localparam logic [4:0] ADDR_IRQ_WORD = 5'h10;

   // control 0 fields
   localparam int C0_EN = 7;
   localparam int C0_OUT = 5;
   localparam int C0_WIDE = 4;
   // control 1 fields
   localparam int C1_ASYNC = 4;
   // irq register fields
   localparam int IRQ_FLAG = 0;
   localparam int IRQ_ENABLE = 1;

   localparam logic [7:0] CTRL0_RESET = 8'h00;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [7:0] CNTL_RESET = 8'h00;
   localparam logic [7:0] CNTH_RESET = 8'hFF;
   localparam logic [7:0] CTRL0_WMASK = 8'h9F;

   // clock source codes
   localparam logic [2:0] CS_PIN_TRUE = 3'h0;
   localparam logic [2:0] CS_PIN_INV = 3'h1;
   localparam logic [2:0] CS_INSTR = 3'h2;
   localparam logic [2:0] CS_FAST_OSC = 3'h3;
   localparam logic [2:0] CS_SLOW_OSC = 3'h4;
   localparam logic [2:0] CS_MED_OSC = 3'h5;
   localparam logic [2:0] CS_SEC_OSC = 3'h6;
   localparam logic [2:0] CS_LOGIC_CELL = 3'h7;

   // instruction clock is core clock / 4
   localparam int INSTR_DIV = 4;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [4:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } tmrc_wb_req_type;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } tmrc_wb_rsp_type;

   typedef struct packed {
      logic pin;
      logic fast_osc;
      logic slow_osc;
      logic med_osc;
      logic sec_osc;
      logic logic_cell;
   } tmrc_clk_src_type;
endpackage

/* File: tmrc_prescale.sv */
// edge detect of the selected source and a 2^n prescaler, one pulse per tick
module tmrc_prescale #(
   parameter int PS_WIDTH = 15
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // control
   input wire logic clear_i,
   input wire logic run_i,
   input wire logic [3:0] ratio_i,
   // source
   input wire logic src_i,
   input wire logic src_en_i,
   // result
   output logic tick_o
);
   logic src_q;
   logic [PS_WIDTH-1:0] count;
   logic [PS_WIDTH:0] wrap_mask;
   logic edge_seen;
   logic next_tick;

   assign edge_seen = src_en_i & src_i & ~src_q;
   assign wrap_mask = (PS_WIDTH+1)'((1 << ratio_i) - 1);
   // all masked bits set means this edge completes the ratio
   assign next_tick = edge_seen &
      (({1'b0, count} & wrap_mask) == wrap_mask);

   always_ff @(posedge clk_i) begin
      if (rst_i | clear_i | ~run_i) begin
         src_q <= 1'b0;
         count <= '0;
         tick_o <= 1'b0;
      end else begin
         // sample only at the enabled rate, so a slow sampler still sees each rise
         if (src_en_i) begin
            src_q <= src_i;
         end
         tick_o <= next_tick;
         if (edge_seen) begin
            count <= next_tick ? '0 : count + 1'b1;
         end
      end
   end
endmodule

/* File: tmrc_timer.sv */
// Behaviour
// [R01] 8-bit: match when low equals period
// [R02] 16-bit: event when count wraps to zero
// [R03] flag set every postscale+1 events
// [R04] flag and enable request an interrupt
// [R05] event pulse lasts one postscaled period; the code holds it one prescaler tick
// [R06] output toggles on each event pulse
// [R07] output routed to pins and peripherals
// [R08] control 0 bit 5 reads output level
// [R09] control 0 bit 7 enables module
// [R10] control 0 bit 4 selects 16-bit
// [R11] control 0 bits 3-0 postscale n+1
// [R12] control 1 bits 7-5 select clock
// [R13] control 1 bit 4 skips synchronisation
// [R14] control 1 bits 3-0 prescale 2^n
// [R15] control 0 bit 6 reads zero
// [R16] two byte holding registers for count
// [R17] match clears low, reloads period buffer
// [R18] 16-bit buffered high via low access
// [R19] writes and reset clear both scalers
// [R20] sync mode halts in sleep
// [R21] software clears flag after handling
//
// The implementer's own choices: the address map and register access over Wishbone.
module tmrc_timer
   import tmrc_pkg::*;
#(
   parameter int PS_WIDTH = 15,
   parameter int POST_WIDTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire tmrc_pkg::tmrc_wb_req_type wb_req_i,
   output tmrc_pkg::tmrc_wb_rsp_type wb_rsp_o,
   // clock sources and sleep
   input wire tmrc_pkg::tmrc_clk_src_type clk_src_i,
   input wire logic sleep_i,
   // outputs
   output logic timer_out_o,
   output logic event_pulse_o,
   output logic irq_o,
   output logic wake_o
);
   import tmrc_pkg::*;

   logic [7:0] timer_control_0;
   logic [7:0] timer_control_1;
   logic [7:0] count_low_byte;
   logic [7:0] count_high_byte;
   logic [7:0] count_high_real;
   logic [7:0] period_buf;
   logic [POST_WIDTH-1:0] post_count;
   logic [1:0] instr_div;
   logic timer_irq_flag;
   logic timer_irq_enable;
   logic output_level_bit;
   logic ack;
   logic [31:0] rdata;

   // bus decode
   wire bus_req = wb_req_i.cyc & wb_req_i.stb & ~ack;
   wire wr_lane = wb_req_i.we & wb_req_i.sel[0];
   wire [3:0] word_adr = wb_req_i.adr[3:0];
   wire adr_hi = wb_req_i.adr[4];
   wire hit_c0 = ~adr_hi & (word_adr == ADDR_CTRL0);
   wire hit_c1 = ~adr_hi & (word_adr == ADDR_CTRL1);
   wire hit_cl = ~adr_hi & (word_adr == ADDR_CNTL);
   wire hit_ch = ~adr_hi & (word_adr == ADDR_CNTH);
   wire hit_irq = (wb_req_i.adr == ADDR_IRQ_WORD);
   wire wr_c0 = bus_req & wr_lane & hit_c0;
   wire wr_c1 = bus_req & wr_lane & hit_c1;
   wire wr_cl = bus_req & wr_lane & hit_cl;
   wire wr_ch = bus_req & wr_lane & hit_ch;
   wire wr_irq = bus_req & wr_lane & hit_irq;
   wire rd_cl = bus_req & ~wb_req_i.we & hit_cl;
   wire [7:0] wdata = wb_req_i.dat[7:0];

   // control fields
   wire module_enable = timer_control_0[C0_EN]; // R09
   wire wide_mode_select = timer_control_0[C0_WIDE]; // R10
   wire [3:0] postscale_select = timer_control_0[3:0]; // R11
   wire [2:0] clock_source_select = timer_control_1[7:5]; // R12
   wire input_unsync_select = timer_control_1[C1_ASYNC]; // R13
   wire [3:0] prescale_select = timer_control_1[3:0]; // R14

   // sync mode samples at the instruction rate; async takes every core edge
   wire instr_tick = (instr_div == 2'(INSTR_DIV - 1));
   // the instruction clock is already in step with the core, so it is taken every edge
   wire src_en = input_unsync_select | instr_tick |
      (clock_source_select == CS_INSTR); // R13

   // clock source multiplexer
   wire src_sel =
      (clock_source_select == CS_PIN_TRUE) ? clk_src_i.pin :
      (clock_source_select == CS_PIN_INV) ? ~clk_src_i.pin :
      (clock_source_select == CS_INSTR) ? instr_div[1] :
      (clock_source_select == CS_FAST_OSC) ? clk_src_i.fast_osc :
      (clock_source_select == CS_SLOW_OSC) ? clk_src_i.slow_osc :
      (clock_source_select == CS_MED_OSC) ? clk_src_i.med_osc :
      (clock_source_select == CS_SEC_OSC) ? clk_src_i.sec_osc :
      clk_src_i.logic_cell; // R12

   // a synchronised timer stops in sleep since its clock is gated there
   wire run = module_enable & ~(sleep_i & ~input_unsync_select); // R09 R20
   wire scaler_clear = wr_cl | wr_c0 | wr_c1; // R19

   logic pre_tick;

   tmrc_prescale #(
      .PS_WIDTH(PS_WIDTH)
   ) u_prescale (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clear_i(scaler_clear),
      .run_i(run),
      .ratio_i(prescale_select),
      .src_i(src_sel),
      .src_en_i(src_en),
      .tick_o(pre_tick)
   );

   // counter events
   wire inc = pre_tick & ~wr_cl;
   wire match8 = ~wide_mode_select & (count_low_byte == period_buf); // R01
   wire roll16 = wide_mode_select &
      ({count_high_real, count_low_byte} == 16'hFFFF); // R02
   wire raw_event = inc & (match8 | roll16);
   wire post_done = (post_count == postscale_select); // R03 R11
   wire post_event = raw_event & post_done;
   wire next_flag = post_event | (timer_irq_flag & ~(wr_irq & ~wdata[IRQ_FLAG]));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         instr_div <= '0;
      end else begin
         instr_div <= instr_div + 2'h1;
      end
   end

   // registers and counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_control_0 <= CTRL0_RESET;
         timer_control_1 <= CTRL1_RESET;
         count_low_byte <= CNTL_RESET;
         count_high_byte <= CNTH_RESET;
         count_high_real <= CNTH_RESET;
         period_buf <= CNTH_RESET;
         timer_irq_enable <= 1'b0;
      end else begin
         if (wr_c0) begin
            timer_control_0 <= wdata & CTRL0_WMASK; // R08 R15
         end
         if (wr_c1) begin
            timer_control_1 <= wdata;
         end
         if (wr_irq) begin
            timer_irq_enable <= wdata[IRQ_ENABLE];
         end
         if (wr_ch) begin
            count_high_byte <= wdata; // R16
         end else if (rd_cl & wide_mode_select) begin
            count_high_byte <= count_high_real; // R18
         end
         if (wr_cl) begin
            count_low_byte <= wdata;
            if (wide_mode_select) begin
               count_high_real <= count_high_byte; // R18
            end
         end else if (inc) begin
            if (match8) begin
               count_low_byte <= '0; // R17
               period_buf <= count_high_byte; // R17
            end else begin
               {count_high_real, count_low_byte} <=
                  {count_high_real, count_low_byte} + 16'h0001; // R02
            end
         end
         // 8-bit mode loads a high byte write straight into the period only while the module is disabled
         if (~wide_mode_select & wr_ch & ~module_enable) begin
            period_buf <= wdata;
         end
      end
   end

   // postscaler, output and interrupt
   always_ff @(posedge clk_i) begin
      if (rst_i | scaler_clear) begin
         post_count <= '0; // R19
      end else if (raw_event) begin
         post_count <= post_done ? '0 : post_count + 1'b1; // R03
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_irq_flag <= 1'b0;
         output_level_bit <= 1'b0;
         event_pulse_o <= 1'b0;
         timer_out_o <= 1'b0;
         irq_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         // the set wins over a clear in the same cycle
         timer_irq_flag <= next_flag; // R03 R21
         // pulse held from one postscaled event until the next tick
         if (pre_tick | ~run) begin
            event_pulse_o <= post_event; // R05
         end
         if (post_event) begin
            output_level_bit <= ~output_level_bit; // R06
            timer_out_o <= ~output_level_bit; // R07
         end
         irq_o <= next_flag & timer_irq_enable; // R04
         wake_o <= next_flag & timer_irq_enable & sleep_i; // R04 R20
      end
   end

   // register read
   wire [7:0] c0_read = {timer_control_0[7], 1'b0, output_level_bit,
      timer_control_0[4:0]}; // R08 R15
   assign rdata =
      hit_c0 ? {24'h000000, c0_read} :
      hit_c1 ? {24'h000000, timer_control_1} :
      hit_cl ? {24'h000000, count_low_byte} :
      hit_ch ? {24'h000000, count_high_byte} :
      hit_irq ? {30'h00000000, timer_irq_enable, timer_irq_flag} :
      32'h00000000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         wb_rsp_o <= '0;
      end else begin
         ack <= bus_req;
         wb_rsp_o.ack <= bus_req;
         wb_rsp_o.dat <= bus_req ? rdata : 32'h00000000;
      end
   end
endmodule

/* File: tmrc_monitor.sv */
module tmrc_monitor
   import tmrc_pkg::*;
#(
   parameter int PS_WIDTH = 15,
   parameter int POST_WIDTH = 4
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire tmrc_pkg::tmrc_wb_req_type wb_req_i,
   input wire tmrc_pkg::tmrc_wb_rsp_type wb_rsp_o,
   // sources and outputs
   input wire tmrc_pkg::tmrc_clk_src_type clk_src_i,
   input wire logic sleep_i,
   input wire logic timer_out_o,
   input wire logic event_pulse_o,
   input wire logic irq_o,
   input wire logic wake_o
);
   import tmrc_pkg::*;
   wire take = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
   wire rd_take = take & ~wb_req_i.we;
   wire wr_take = take & wb_req_i.we;
   wire rd_ctrl0 = rd_take & (wb_req_i.adr == 5'h00);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_next: assert property (take |=> wb_rsp_o.ack)
      else $error("no ack after request");
   a_ack_single: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack too long");
   a_unmapped_zero: assert property (
      rd_take && wb_req_i.adr == 5'h14 |=> wb_rsp_o.dat == 32'h0)
      else $error("unmapped read not zero");
   a_bit6_zero: assert property (rd_ctrl0 |=> !wb_rsp_o.dat[6])
      else $error("control 0 bit 6 set");
   a_out_mirror: assert property (rd_ctrl0 |=> wb_rsp_o.dat[5] == $past(timer_out_o))
      else $error("output bit differs");
   a_toggle_pulse: assert property ($rose(event_pulse_o) |-> $changed(timer_out_o))
      else $error("no toggle on pulse");
   a_irq_hold: assert property (irq_o && !wr_take && !$past(wr_take) |=> irq_o)
      else $error("irq dropped alone");
   a_reset_quiet: assert property (disable iff (1'b0)
      rst_i |=> !irq_o && !wb_rsp_o.ack && !timer_out_o && !event_pulse_o)
      else $error("outputs active after reset");
   c_pulse: cover property ($rose(event_pulse_o));
   c_irq_clear: cover property ($fell(irq_o));
   c_unmapped: cover property (rd_take && wb_req_i.adr == 5'h14);
endmodule

bind tmrc_timer tmrc_monitor #(.PS_WIDTH(PS_WIDTH), .POST_WIDTH(POST_WIDTH)) mon_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
   .clk_src_i(clk_src_i), .sleep_i(sleep_i), .timer_out_o(timer_out_o),
   .event_pulse_o(event_pulse_o), .irq_o(irq_o), .wake_o(wake_o));

/* File: tmrc_timer_tb.sv */
module tmrc_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import tmrc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   tmrc_wb_req_type wb_req_i = '0;
   tmrc_wb_rsp_type wb_rsp_o;
   tmrc_clk_src_type clk_src_i = '0;
   logic sleep_i = 1'b0;
   logic timer_out_o, event_pulse_o, irq_o, wake_o;
   int n_mismatch = 0;
   int check_count = 0;
   // cs, postscale, period, expected clocks between pulses
   logic [7:0] c1 [4] = '{8'h40, 8'h41, 8'hF0, 8'h30};
   logic [7:0] c0 [4] = '{8'h01, 8'h00, 8'h0F, 8'h00};
   logic [7:0] hv [4] = '{8'h03, 8'h02, 8'h01, 8'h01};
   logic [15:0] ex [4] = '{16'h0020, 16'h0018, 16'h0040, 16'h0080};

   tmrc_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
      .clk_src_i(clk_src_i), .sleep_i(sleep_i), .timer_out_o(timer_out_o),
      .event_pulse_o(event_pulse_o), .irq_o(irq_o), .wake_o(wake_o));

   always #50 clk_i = ~clk_i;
   // every source runs at its own rate: pin every 64 clocks, logic cell every 2
   always @(posedge clk_i) clk_src_i <= tmrc_clk_src_type'(clk_src_i + 6'h01);

   task automatic stop_test;
      $display("compares %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
      int k;
      k = 0;
      @(posedge clk_i);
      wb_req_i <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_rsp_o.ack !== 1'b1 && k < 50);
      q = wb_rsp_o.dat[7:0];
      wb_req_i <= '0;
      if (k >= 50) begin
         n_mismatch++;
         stop_test();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(a, 1'b1, d, q);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      logic [7:0] q;
      wb(a, 1'b0, 8'h00, q);
      cmp({8'h00, q}, {8'h00, e});
   endtask

   // counts clocks until the pulse reaches the given level
   task automatic wait_ev(input logic lvl, output int k);
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
      end while (event_pulse_o !== lvl && k < 3000);
      if (k >= 3000) begin
         n_mismatch++;
         stop_test();
      end
   endtask

   initial begin
      int a;
      int b;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(5'h00, 8'h00);
      rd(5'h04, 8'h00);
      rd(5'h08, 8'h00);
      rd(5'h0C, 8'hFF);
      rd(5'h14, 8'h00);
      wr(5'h00, 8'h7F);
      rd(5'h00, 8'h1F);
      wr(5'h04, 8'hFF);
      rd(5'h04, 8'hFF);
      wr(5'h0C, 8'h12);
      wr(5'h08, 8'h34);
      rd(5'h08, 8'h34);
      rd(5'h0C, 8'h12);
      wr(5'h10, 8'h02);
      wr(5'h0C, 8'hFF);
      wr(5'h08, 8'hFE);
      wr(5'h04, 8'h50);
      wr(5'h00, 8'h90);
      wait_ev(1'b1, a);
      repeat (2) @(negedge clk_i);
      cmp({15'h0, irq_o}, 16'h0001);
      @(posedge clk_i);
      sleep_i <= 1'b1;
      repeat (2) @(negedge clk_i);
      cmp({15'h0, wake_o}, 16'h0001);
      @(posedge clk_i);
      sleep_i <= 1'b0;
      rd(5'h00, 8'hB0);
      rd(5'h10, 8'h03);
      wr(5'h10, 8'h02);
      repeat (2) @(negedge clk_i);
      cmp({15'h0, irq_o}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wr(5'h00, 8'h00);
         wr(5'h0C, hv[i]);
         wr(5'h08, 8'h00);
         wr(5'h04, c1[i]);
         wr(5'h00, 8'h80 | c0[i]);
         wait_ev(1'b0, a);
         wait_ev(1'b1, a);
         wait_ev(1'b0, a);
         wait_ev(1'b1, b);
         cmp(16'(a + b), ex[i]);
      end
      stop_test();
   end
endmodule
